// ---- bench/lpm_wake_model.sv ----
// wake pin driver model standing for the external party on the deep standby wake pins
`timescale 1ns/100ps
module lpm_wake_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic stb,
  input wire logic [3:0] idx,
  input wire logic lvl,
  input wire logic [3:0] lag,
  output logic [15:0] pins
);
  logic [3:0] cnt;
  logic pend;
  logic [3:0] pIdx;
  logic pLvl;
  // a requested level change lands lag plus one cycles after the strobe, so the pins can answer promptly or slowly
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pins <= 16'h0000;
      pend <= 1'b0;
      cnt <= 4'h0;
      pIdx <= 4'h0;
      pLvl <= 1'b0;
    end else if (stb) begin
      pend <= 1'b1;
      cnt <= lag;
      pIdx <= idx;
      pLvl <= lvl;
    end else if (pend && cnt == 4'h0) begin
      pins[pIdx] <= pLvl;
      pend <= 1'b0;
    end else if (pend) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule

// ---- bench/tb_top.sv ----
// self-checking testbench of the low-power mode controller
`timescale 1ns/100ps
`include "lpm_map.svh"
module tb_top;
  import lpm_pkg::*;
  localparam int SC = 8;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic wfiExec = 1'b0;
  lpm_apb_req_t req = '0;
  lpm_apb_rsp_t rsp;
  logic [15:0] pins;
  logic deepStandby, pllAvailable, lowSpeedApplied, midOscRun;
  logic wStb = 1'b0;
  logic [3:0] wIdx = 4'h0;
  logic wLvl = 1'b0;
  logic [3:0] wLag = 4'h0;
  int n_mismatch = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic err;
  logic [3:0] sel, pin;
  logic de, ed;
  logic [15:0] wEdge;
  int n;
  // clock
  always #2.5 mclk = ~mclk;
  lpm_controller #(.WAKE_PINS(16), .SETTLE_CYC(SC)) DUT (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
    .apbReq(req), .apbRsp(rsp), .wfiExec(wfiExec), .deepStandbyWakePin(pins), .deepStandby(deepStandby),
    .pllAvailable(pllAvailable), .lowSpeedApplied(lowSpeedApplied), .midOscRun(midOscRun));
  lpm_wake_model wake (.mclk(mclk), .rst_n(rst_n), .stb(wStb), .idx(wIdx), .lvl(wLvl), .lag(wLag), .pins(pins));
  // verdict and end of run
  task automatic complete_run;
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // compare and report
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; pready, read data and error are taken at the rising edge that completes it
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    @(posedge mclk);
    while (rsp.pready !== 1'b1 && k < 50) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 50) n_mismatch++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask
  // poll the transition flag under a bounded count
  task automatic waitFlag;
    int k;
    k = 0;
    do begin
      xfer(1'b0, `LPM_OFS_OPMODE, 32'h0);
      k++;
    end while (rd[4] !== 1'b0 && k < 20);
    check("flagClear", 32'(rd[4]), 32'h0);
  endtask
  function automatic logic expDeep(input logic [3:0] s, input logic e);
    return e && (s == `LPM_LPSEL_DEEP0 || s == `LPM_LPSEL_DEEP1 || s == `LPM_LPSEL_DEEP2);
  endfunction
  // watchdog
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  // main sequence
  initial begin
    void'($urandom(32'h3CEC8596));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) rdChk("resetVal", 12'(i * 4), (i == 4) ? 32'h2 : 32'h0);
    xfer(1'b0, 12'h014, 32'h0);
    check("unmappedErr", 32'(err), 32'h1);
    xfer(1'b1, 12'h002, 32'h3);
    check("unalignedErr", 32'(err), 32'h1);
    // to low speed: flag seen 1, loops withdrawn, busy write dropped, flag frozen with clkEn low
    waitFlag();
    xfer(1'b1, `LPM_OFS_OPMODE, 32'h3);
    @(negedge mclk);
    check("pllOffLs", 32'(pllAvailable), 32'h0);
    xfer(1'b1, `LPM_OFS_OPMODE, 32'h0);
    clkEn <= 1'b0;
    repeat (30) @(posedge mclk);
    clkEn <= 1'b1;
    rdChk("flagBusy", `LPM_OFS_OPMODE, 32'h13);
    waitFlag();
    rdChk("modeLs", `LPM_OFS_OPMODE, 32'h3);
    check("lsApplied", 32'(lowSpeedApplied), 32'h1);
    for (int c = 1; c < 3; c++) begin
      xfer(1'b1, `LPM_OFS_OPMODE, 32'(c));
      rdChk("reservedMode", `LPM_OFS_OPMODE, 32'h3);
    end
    // back to high speed; clocks raised only after the flag clears
    xfer(1'b1, `LPM_OFS_OPMODE, 32'h0);
    waitFlag();
    rdChk("modeHs", `LPM_OFS_OPMODE, 32'h0);
    check("pllBack", 32'(pllAvailable), 32'h1);
    check("hsApplied", 32'(lowSpeedApplied), 32'h0);
    // oscillator stop bit
    xfer(1'b1, `LPM_OFS_CTRL, 32'h10000);
    @(negedge mclk);
    check("midOscStop", 32'(midOscRun), 32'h0);
    xfer(1'b1, `LPM_OFS_CTRL, 32'h0);
    @(negedge mclk);
    check("midOscRun", 32'(midOscRun), 32'h1);
    // deep standby entry and wake, corner codes first then random
    for (int i = 0; i < 14; i++) begin
      sel = (i < 3) ? 4'(8 + i) : (i == 3) ? 4'hB : (i == 4) ? 4'h8 : 4'($urandom_range(11, 7));
      de = (i == 4) ? 1'b0 : (i < 4) ? 1'b1 : 1'($urandom);
      pin = 4'($urandom);
      ed = (i < 3) ? 1'b1 : 1'($urandom);
      wEdge = 16'($urandom);
      wEdge[pin] = ed;
      xfer(1'b1, `LPM_OFS_WAKEEN, 32'(16'h0001 << pin));
      xfer(1'b1, `LPM_OFS_WAKEEDGE, {16'h0000, wEdge});
      rdChk("edgeSel", `LPM_OFS_WAKEEDGE, {16'h0000, wEdge});
      wStb <= 1'b1;
      wIdx <= pin;
      wLvl <= ~ed;
      wLag <= 4'h0;
      @(posedge mclk);
      wStb <= 1'b0;
      repeat (4) @(posedge mclk);
      xfer(1'b1, `LPM_OFS_CTRL, {23'h0, de, 4'h0, sel});
      wfiExec <= 1'b1;
      @(posedge mclk);
      wfiExec <= 1'b0;
      @(negedge mclk);
      check("deepEntry", 32'(deepStandby), 32'(expDeep(sel, de)));
      if (expDeep(sel, de)) begin
        @(posedge mclk);
        wStb <= 1'b1;
        wLvl <= ed;
        wLag <= 4'($urandom_range(7, 0));
        @(posedge mclk);
        wStb <= 1'b0;
        n = 0;
        while (deepStandby !== 1'b0 && n < 16) begin
          @(negedge mclk);
          n++;
        end
        check("deepWake", 32'(deepStandby), 32'h0);
        rdChk("wakeSrc", `LPM_OFS_STATUS, {16'h0001 << pin, 16'h0002});
      end
    end
    complete_run();
  end
endmodule

// ---- verilog/lpm_controller.sv ----
// low-power mode controller: deep standby entry and wake, operating power mode switching
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "lpm_map.svh"
module lpm_controller #(
  parameter int WAKE_PINS = `LPM_WAKE_PINS,
  parameter int SETTLE_CYC = `LPM_MODE_SETTLE_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire lpm_pkg::lpm_apb_req_t apbReq,
  output lpm_pkg::lpm_apb_rsp_t apbRsp,
  input wire logic wfiExec,
  input wire logic [WAKE_PINS-1:0] deepStandbyWakePin,
  output logic deepStandby,
  output logic pllAvailable,
  output logic lowSpeedApplied,
  output logic midOscRun
);
  import lpm_pkg::*;

  // software-visible control state
  logic [3:0] lpSel;
  logic deepEn;
  logic moStop;
  logic [WAKE_PINS-1:0] wakeEdge;
  logic [WAKE_PINS-1:0] wakeEn;
  lpm_opmode_t targetMode;
  lpm_opmode_t appliedMode;
  logic [3:0] next_lpSel;
  logic next_deepEn;
  logic next_moStop;
  logic [WAKE_PINS-1:0] next_wakeEdge;
  logic [WAKE_PINS-1:0] next_wakeEn;
  lpm_opmode_t next_targetMode;
  lpm_opmode_t next_appliedMode;

  // standby sequence state
  lpm_state_t state;
  lpm_state_t next_state;
  logic [WAKE_PINS-1:0] wakeSrc;
  logic [WAKE_PINS-1:0] next_wakeSrc;

  // bus answer state
  logic [31:0] rdData;
  logic rdErr;
  logic rspReady;
  logic [31:0] next_rdData;
  logic next_rdErr;
  logic next_rspReady;

  // decoded bus and helper signals
  logic setupPh;
  logic wrStrobe;
  logic [31:0] rdMux;
  logic rdMiss;
  logic [31:0] ctrlWord;
  logic [31:0] opmWord;
  logic [31:0] statWord;
  logic [1:0] wrMode;
  logic modeLegal;
  logic modeWrAcc;
  logic modeBusy;
  logic modeLast;
  logic deepCond;
  logic [WAKE_PINS-1:0] wakeHit;

  // apb phase decode; the answer waits one cycle so read data comes from flops
  assign setupPh = apbReq.psel && !apbReq.penable;
  assign apbRsp.pready = apbReq.psel && apbReq.penable && rspReady && clkEn;
  assign apbRsp.pslverr = rdErr && apbRsp.pready;
  assign apbRsp.prdata = rdData;
  assign wrStrobe = apbRsp.pready && apbReq.pwrite && !rdErr;

  // mode field writes: only the two legal codes, only while no transition runs
  assign wrMode = apbReq.pwdata[`LPM_OPM_FIELD_MSB:`LPM_OPM_FIELD_LSB];
  assign modeLegal = (wrMode == `LPM_OPM_HIGH) || (wrMode == `LPM_OPM_LOW);
  assign modeWrAcc = wrStrobe && (apbReq.paddr == `LPM_OFS_OPMODE) && modeLegal && !modeBusy;

  // deep standby request condition on the sleep instruction
  assign deepCond = deepEn && ((lpSel == `LPM_LPSEL_DEEP0) || (lpSel == `LPM_LPSEL_DEEP1)
                    || (lpSel == `LPM_LPSEL_DEEP2));

  // outputs seen by the clock and power fabric
  assign deepStandby = (state == LPM_STBY);
  assign lowSpeedApplied = (appliedMode == LPM_OPM_LS);
  assign pllAvailable = (appliedMode == LPM_OPM_HS) && (targetMode == LPM_OPM_HS) && !modeBusy;
  assign midOscRun = !moStop;

  // readable register words
  always_comb begin
    ctrlWord = 32'h0000_0000;
    ctrlWord[`LPM_CTRL_LPSEL_MSB:`LPM_CTRL_LPSEL_LSB] = lpSel;
    ctrlWord[`LPM_CTRL_DEEP_BIT] = deepEn;
    ctrlWord[`LPM_CTRL_MOSTOP_BIT] = moStop;
    opmWord = 32'h0000_0000;
    opmWord[`LPM_OPM_FIELD_MSB:`LPM_OPM_FIELD_LSB] = targetMode;
    opmWord[`LPM_OPM_FLAG_BIT] = modeBusy;
    statWord = 32'h0000_0000;
    statWord[`LPM_STAT_STBY_BIT] = deepStandby;
    statWord[`LPM_STAT_PLL_BIT] = pllAvailable;
    statWord[`LPM_STAT_LOWAPP_BIT] = lowSpeedApplied;
    statWord[`LPM_STAT_WAKESRC_LSB +: WAKE_PINS] = wakeSrc;
  end

  // read multiplexer, unmapped offsets answer with an error
  always_comb begin
    rdMux = 32'h0000_0000;
    rdMiss = 1'b0;
    case (apbReq.paddr)
      `LPM_OFS_CTRL: begin
        rdMux = ctrlWord;
      end
      `LPM_OFS_OPMODE: begin
        rdMux = opmWord;
      end
      `LPM_OFS_WAKEEDGE: begin
        rdMux = 32'(wakeEdge);
      end
      `LPM_OFS_WAKEEN: begin
        rdMux = 32'(wakeEn);
      end
      `LPM_OFS_STATUS: begin
        rdMux = statWord;
      end
      default: begin
        rdMiss = 1'b1;
      end
    endcase
  end

  // bus answer: capture in the setup cycle, release after the access completes
  always_comb begin
    next_rdData = rdData;
    next_rdErr = rdErr;
    next_rspReady = rspReady;
    if (setupPh) begin
      next_rdData = apbReq.pwrite ? 32'h0000_0000 : rdMux;
      next_rdErr = rdMiss;
      next_rspReady = 1'b1;
    end else if (apbRsp.pready) begin
      next_rspReady = 1'b0;
    end
  end

  // bus answer registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdData <= 32'h0000_0000;
      rdErr <= 1'b0;
      rspReady <= 1'b0;
    end else if (clkEn) begin
      rdData <= next_rdData;
      rdErr <= next_rdErr;
      rspReady <= next_rspReady;
    end
  end

  // control register writes and mode hand-over at the end of a transition
  always_comb begin
    next_lpSel = lpSel;
    next_deepEn = deepEn;
    next_moStop = moStop;
    next_wakeEdge = wakeEdge;
    next_wakeEn = wakeEn;
    next_targetMode = targetMode;
    next_appliedMode = appliedMode;
    if (wrStrobe && apbReq.paddr == `LPM_OFS_CTRL) begin
      next_lpSel = apbReq.pwdata[`LPM_CTRL_LPSEL_MSB:`LPM_CTRL_LPSEL_LSB];
      next_deepEn = apbReq.pwdata[`LPM_CTRL_DEEP_BIT];
      next_moStop = apbReq.pwdata[`LPM_CTRL_MOSTOP_BIT];
    end
    if (wrStrobe && apbReq.paddr == `LPM_OFS_WAKEEDGE) begin
      next_wakeEdge = apbReq.pwdata[WAKE_PINS-1:0];
    end
    if (wrStrobe && apbReq.paddr == `LPM_OFS_WAKEEN) begin
      next_wakeEn = apbReq.pwdata[WAKE_PINS-1:0];
    end
    if (modeWrAcc) begin
      next_targetMode = lpm_opmode_t'(wrMode);
    end
    if (modeLast) begin
      next_appliedMode = targetMode;
    end
  end

  // control registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lpSel <= `LPM_LPSEL_RESET;
      deepEn <= `LPM_DEEP_RESET;
      moStop <= `LPM_MOSTOP_RESET;
      wakeEdge <= WAKE_PINS'(`LPM_WAKE_RESET);
      wakeEn <= WAKE_PINS'(`LPM_WAKE_RESET);
      targetMode <= LPM_OPM_HS;
      appliedMode <= LPM_OPM_HS;
    end else if (clkEn) begin
      lpSel <= next_lpSel;
      deepEn <= next_deepEn;
      moStop <= next_moStop;
      wakeEdge <= next_wakeEdge;
      wakeEn <= next_wakeEn;
      targetMode <= next_targetMode;
      appliedMode <= next_appliedMode;
    end
  end

  // transition timer behind the power mode flag
  lpm_mode_timer #(
    .CYC(SETTLE_CYC)
  ) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .start(modeWrAcc),
    .busy(modeBusy),
    .lastCycle(modeLast)
  );

  // wake edge detectors, armed only in deep standby
  lpm_wake_detect #(
    .PINS(WAKE_PINS)
  ) u_wake (
    .mclk(mclk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .arm(state == LPM_STBY),
    .pins(deepStandbyWakePin),
    .edgeRise(wakeEdge),
    .enable(wakeEn),
    .hit(wakeHit)
  );

  // standby sequence: enter on the sleep instruction, leave on a wake hit
  always_comb begin
    next_state = state;
    next_wakeSrc = wakeSrc;
    unique case (state)
      LPM_RUN: begin
        if (wfiExec && deepCond) begin
          next_state = LPM_STBY;
          next_wakeSrc = '0;
        end
      end
      LPM_STBY: begin
        if (|wakeHit) begin
          next_state = LPM_EXIT;
          next_wakeSrc = wakeHit;
        end
      end
      LPM_EXIT: begin
        next_state = LPM_RUN;
      end
      default: begin
        next_state = LPM_RUN;
      end
    endcase
  end

  // standby sequence registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= LPM_RUN;
      wakeSrc <= '0;
    end else if (clkEn) begin
      state <= next_state;
      wakeSrc <= next_wakeSrc;
    end
  end

  // checks on the controller behaviour
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence sWfiDeep;
    state == LPM_RUN && wfiExec && deepCond && clkEn;
  endsequence

  sequence sWakeRise;
    deepStandby && clkEn && $past(clkEn)
      && |(deepStandbyWakePin & ~$past(deepStandbyWakePin) & wakeEdge & wakeEn);
  endsequence

  sequence sModeWrite;
    modeWrAcc && clkEn;
  endsequence

  AST_DEEP_ENTRY:
  assert property (sWfiDeep |=> deepStandby) else $error("deep standby not entered");
  AST_NO_ENTRY_OTHER_MODES:
  assert property (state == LPM_RUN && wfiExec && !deepCond |=> !deepStandby) else $error("standby without mode");
  AST_WAKE_ON_RISE:
  assert property (sWakeRise ##1 clkEn |=> !deepStandby) else $error("rising wake edge ignored");
  AST_LS_NO_PLL:
  assert property (lowSpeedApplied |-> !pllAvailable) else $error("loop available in low-speed");
  AST_FLAG_ON_WRITE:
  assert property (sModeWrite |=> modeBusy ##1 modeBusy) else $error("transition flag not raised");
  AST_APPLY_AT_FLAG_FALL:
  assert property ($fell(modeBusy) |-> appliedMode == targetMode) else $error("mode not applied at end");
  AST_RESERVED_MODE_IGNORED:
  assert property (wrStrobe && apbReq.paddr == `LPM_OFS_OPMODE && !modeLegal && !modeBusy
                   |=> !modeBusy && $stable(targetMode)) else $error("reserved mode code accepted");
  AST_LS_WRITE_TARGET:
  assert property ((sModeWrite and (wrMode == `LPM_OPM_LOW)) |=> targetMode == LPM_OPM_LS) else $error("low code lost");
  AST_HS_WRITE_TARGET:
  assert property ((sModeWrite and (wrMode == `LPM_OPM_HIGH)) |=> targetMode == LPM_OPM_HS) else $error("high code lost");
  AST_FREEZE:
  assert property (!clkEn |=> $stable(state) && $stable(appliedMode)) else $error("state moved while frozen");
endmodule

// ---- verilog/lpm_map.svh ----
// register map, field positions, reset values and timing counts of the low-power mode controller
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH
// apb address width and register byte offsets
`define LPM_APB_AW 12
`define LPM_OFS_CTRL 12'h000
`define LPM_OFS_OPMODE 12'h004
`define LPM_OFS_WAKEEDGE 12'h008
`define LPM_OFS_WAKEEN 12'h00C
`define LPM_OFS_STATUS 12'h010
// control word fields
`define LPM_CTRL_LPSEL_LSB 0
`define LPM_CTRL_LPSEL_MSB 3
`define LPM_CTRL_DEEP_BIT 8
`define LPM_CTRL_MOSTOP_BIT 16
// low power mode select codes that lead into deep standby
`define LPM_LPSEL_DEEP0 4'h8
`define LPM_LPSEL_DEEP1 4'h9
`define LPM_LPSEL_DEEP2 4'hA
// operating power mode word fields
`define LPM_OPM_FIELD_LSB 0
`define LPM_OPM_FIELD_MSB 1
`define LPM_OPM_FLAG_BIT 4
`define LPM_OPM_HIGH 2'h0
`define LPM_OPM_LOW 2'h3
// status word fields
`define LPM_STAT_STBY_BIT 0
`define LPM_STAT_PLL_BIT 1
`define LPM_STAT_LOWAPP_BIT 2
`define LPM_STAT_WAKESRC_LSB 16
// reset values
`define LPM_LPSEL_RESET 4'h0
`define LPM_DEEP_RESET 1'h0
`define LPM_MOSTOP_RESET 1'h0
`define LPM_WAKE_RESET 16'h0000
// wake pins and mode settling time
`define LPM_WAKE_PINS 16
`define LPM_CLK_PERIOD_NS 5
`define LPM_MODE_SETTLE_NS 100
`define LPM_MODE_SETTLE_CYC ((`LPM_MODE_SETTLE_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS)
`endif

// ---- verilog/lpm_mode_timer.sv ----
// settling timer behind the power mode transition flag
`timescale 1ns/100ps
module lpm_mode_timer #(
  parameter int CYC = 20
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic start,
  output logic busy,
  output logic lastCycle
);
  import lpm_pkg::*;
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_busy;
  assign lastCycle = busy && (cnt == CW'(CYC - 1));
  // start only from idle, then count the settling cycles
  always_comb begin
    next_busy = busy;
    next_cnt = cnt;
    if (!busy && start) begin
      next_busy = 1'b1;
      next_cnt = '0;
    end else if (lastCycle) begin
      next_busy = 1'b0;
    end else if (busy) begin
      next_cnt = cnt + CW'(1);
    end
  end
  // timer registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= '0;
    end else if (clkEn) begin
      busy <= next_busy;
      cnt <= next_cnt;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_BUSY_ENDS_ON_COUNT:
  assert property (busy && clkEn && cnt == CW'(CYC - 1) |=> !busy) else $error("transition flag overstays");
endmodule

// ---- verilog/lpm_pkg.sv ----
// types shared by the low-power mode controller files
`include "lpm_map.svh"
package lpm_pkg;
  // standby sequence states, gray coded along run, standby, exit
  typedef enum logic [1:0] {
    LPM_RUN = 2'b00,
    LPM_STBY = 2'b01,
    LPM_EXIT = 2'b11
  } lpm_state_t;
  // operating power control modes
  typedef enum logic [1:0] {
    LPM_OPM_HS = `LPM_OPM_HIGH,
    LPM_OPM_LS = `LPM_OPM_LOW
  } lpm_opmode_t;
  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`LPM_APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } lpm_apb_req_t;
  // apb answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lpm_apb_rsp_t;
endpackage

// ---- verilog/lpm_wake_detect.sv ----
// per-pin edge detector for the deep standby wake pins
`timescale 1ns/100ps
module lpm_wake_detect #(
  parameter int PINS = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic arm,
  input wire logic [PINS-1:0] pins,
  input wire logic [PINS-1:0] edgeRise,
  input wire logic [PINS-1:0] enable,
  output logic [PINS-1:0] hit
);
  import lpm_pkg::*;
  logic [PINS-1:0] prev;
  logic [PINS-1:0] next_hit;
  // one edge detector per pin; set select picks rising, clear picks falling
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    always_comb begin
      if (edgeRise[i]) begin
        next_hit[i] = arm && enable[i] && pins[i] && !prev[i];
      end else begin
        next_hit[i] = arm && enable[i] && !pins[i] && prev[i];
      end
    end
  end
  // history and hit registers, frozen while the clock enable is low
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prev <= '0;
      hit <= '0;
    end else if (clkEn) begin
      prev <= pins;
      hit <= next_hit;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_HIT_NEEDS_ARM:
  assert property (|hit |-> $past(arm)) else $error("wake hit without armed standby");
endmodule
